// ===== common/fdpc_pkg.sv
// Constants, types and helpers shared by the flash download and parameter check block
package fdpc_pkg;

  // ---------------------------------------------------------------
  // Download window
  // ---------------------------------------------------------------
  localparam logic [23:0] RAM_BASE0 = 24'hFF9000;
  localparam logic [23:0] RAM_BASE1 = 24'hFFA000;
  localparam logic [23:0] RAM_BASE2 = 24'hFFB000;
  localparam logic [6:0] DEST_CODE_MAX = 7'h02;
  localparam logic [11:0] ROUTINE_LAST = 12'hFFF;
  localparam logic [12:0] ROUTINE_BYTES = 13'h1000;
  localparam int DEST_ERR_BIT = 7;
  localparam logic [7:0] STACK_BYTES = 8'h80;

  // ---------------------------------------------------------------
  // Key, array select and parameter limits
  // ---------------------------------------------------------------
  localparam logic [7:0] KEY_COPY = 8'hA5;
  localparam logic [7:0] KEY_PROG = 8'h5A;
  localparam logic [7:0] ARRAY_BOOT_SEL = 8'hAA;
  localparam logic [15:0] FREQ_MIN = 16'h0320;
  localparam logic [15:0] FREQ_MAX = 16'h1388;
  localparam logic [31:0] FLASH_LO = 32'h00000000;
  localparam logic [31:0] FLASH_HI = 32'h0007FFFF;
  localparam logic [31:0] ERASE_BLK_MAX = 32'h00000013;
  localparam logic [7:0] ALIGN_LO = 8'h00;
  localparam logic [7:0] ALIGN_HI = 8'h80;

  // ---------------------------------------------------------------
  // Result byte bit positions
  // ---------------------------------------------------------------
  localparam int PASS_FAIL = 0;
  localparam int KEY_CHECK_ERROR = 1;
  localparam int SRC_SEL_ERROR = 2;
  localparam int FREQ_ERROR = 1;
  localparam int DEST_ADDR_ERROR = 1;
  localparam int SOURCE_ADDR_ERROR = 2;
  localparam int ERASE_BLK_ERROR = 3;
  localparam int OP_KEY_ERROR = 4;
  localparam int EXEC_ERROR = 5;
  localparam int PROTECT_STATE_ERROR = 6;

  typedef enum logic [1:0] {
    OP_INIT = 2'h0,
    OP_PROG = 2'h1,
    OP_ERASE = 2'h2
  } fdpc_op_t;

  typedef enum logic [2:0] {
    DL_IDLE, DL_COPY_RD, DL_COPY_WR, DL_VER_RD, DL_VER_CMP, DL_RESULT
  } fdpc_dl_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic we;
  } fdpc_ram_req_t;

  typedef struct packed {
    fdpc_dl_t fsm;
    logic [7:0] dstSel;
    logic [23:0] base;
    logic [11:0] idx;
    logic [11:0] romAddr;
    fdpc_ram_req_t ram;
    logic [7:0] dlResult;
    logic busy;
    logic mismatch;
    logic dlDone;
    logic opDone;
    logic [7:0] result;
  } fdpc_state_t;

  // Base address of the download window for a legal destination code
  function automatic logic [23:0] fdpc_dest_base(input logic [6:0] code);
    logic [23:0] b;
    b = RAM_BASE0;
    if (code == 7'h01) begin
      b = RAM_BASE1;
    end else if (code == 7'h02) begin
      b = RAM_BASE2;
    end
    return b;
  endfunction : fdpc_dest_base

endpackage : fdpc_pkg

// ===== logic/fdpc_range_chk.sv
// Inclusive range comparator used for the frequency, flash address and erase block range checks
`timescale 1ns/10ps
module fdpc_range_chk #(
  parameter int W = 32,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
) (
  input wire logic [W-1:0] value,
  output logic inRange
);

  // Both bounds inclusive
  assign inRange = (value >= LO) && (value <= HI);

endmodule : fdpc_range_chk

// ===== logic/fdpc_top.sv
// Routine download sequencer and programming/erasing parameter checker
`timescale 1ns/10ps
module fdpc_top
  import fdpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic standby,
  input wire logic destSelWe,
  input wire logic [7:0] destSelWdata,
  output logic [7:0] destSelRdata,
  input wire logic copyRequest,
  output logic copyBusy,
  output logic dlDone,
  input wire logic progSelect,
  input wire logic eraseSelect,
  input wire logic [7:0] unlockKey,
  input wire logic [7:0] arraySelect,
  input wire logic flashErrorFlag,
  output logic [11:0] romAddr,
  input wire logic [7:0] romData,
  output fdpc_ram_req_t ramReq,
  input wire logic [7:0] ramRdata,
  input wire logic opStart,
  input wire fdpc_op_t opKind,
  input wire logic [31:0] paramRegA,
  input wire logic [31:0] paramRegB,
  input wire logic notErased,
  output logic opDone,
  output logic [7:0] resultLowByte
);

  // ---------------------------------------------------------------
  // Parameter range checks
  // ---------------------------------------------------------------
  logic freqOk;
  logic destInFlash;
  logic srcInFlash;
  logic blockOk;

  fdpc_range_chk #(.W(16), .LO(FREQ_MIN), .HI(FREQ_MAX)) uFreq (
    .value(paramRegA[15:0]),
    .inRange(freqOk)
  );
  fdpc_range_chk #(.W(32), .LO(FLASH_LO), .HI(FLASH_HI)) uDest (
    .value(paramRegB),
    .inRange(destInFlash)
  );
  fdpc_range_chk #(.W(32), .LO(FLASH_LO), .HI(FLASH_HI)) uSrc (
    .value(paramRegA),
    .inRange(srcInFlash)
  );
  fdpc_range_chk #(.W(32), .LO(32'h00000000), .HI(ERASE_BLK_MAX)) uBlk (
    .value(paramRegA),
    .inRange(blockOk)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fdpc_state_t st_q;
  fdpc_state_t st_d;

  logic [6:0] codeNow;
  logic destCodeBad;
  logic selErr;
  logic keyCopyErr;
  logic keyProgErr;
  logic bootSel;
  logic destBad;
  logic [7:0] opRes;

  // Code in force at the trigger; a write in the same cycle takes effect at once.
  // Taken from the inputs, not from st_d, so no loop runs through the next state.
  assign codeNow = destSelWe ? destSelWdata[6:0] : st_q.dstSel[6:0];
  assign destCodeBad = codeNow > DEST_CODE_MAX;
  // Exactly one routine must be chosen; none or both is a selection error
  assign selErr = ~(progSelect ^ eraseSelect);
  assign keyCopyErr = unlockKey != KEY_COPY;
  assign keyProgErr = unlockKey != KEY_PROG;
  assign bootSel = arraySelect == ARRAY_BOOT_SEL;
  // Destination must be in flash and on a 128-byte boundary
  assign destBad = ~destInFlash |
                   ((paramRegB[7:0] != ALIGN_LO) && (paramRegB[7:0] != ALIGN_HI));

  // Result byte of the call in progress; unused bits stay zero
  always_comb begin
    opRes = 8'h00;
    unique case (opKind)
      OP_INIT: begin
        opRes[FREQ_ERROR] = ~freqOk;
      end
      OP_PROG: begin
        opRes[PROTECT_STATE_ERROR] = flashErrorFlag;
        opRes[EXEC_ERROR] = notErased | bootSel;
        opRes[OP_KEY_ERROR] = keyProgErr;
        opRes[SOURCE_ADDR_ERROR] = srcInFlash;
        opRes[DEST_ADDR_ERROR] = destBad;
      end
      OP_ERASE: begin
        opRes[PROTECT_STATE_ERROR] = flashErrorFlag;
        opRes[EXEC_ERROR] = notErased | bootSel;
        opRes[OP_KEY_ERROR] = keyProgErr;
        opRes[ERASE_BLK_ERROR] = ~blockOk;
      end
      default: begin
        opRes = 8'h00;
      end
    endcase
    // Undefined kinds report plain failure rather than a false pass
    opRes[PASS_FAIL] = (|opRes[7:1]) | (opKind == 2'h3);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // The result byte overwrites the first routine byte, so the
  // read-back check runs before it is written.
  always_comb begin
    st_d = st_q;
    st_d.ram.we = 1'b0;
    st_d.dlDone = 1'b0;
    st_d.opDone = 1'b0;
    if (destSelWe) begin
      st_d.dstSel = destSelWdata;
    end
    // Caller keeps up to STACK_BYTES of stack free for saved registers
    if (opStart) begin
      st_d.result = opRes;
      st_d.opDone = 1'b1;
    end
    unique case (st_q.fsm)
      DL_IDLE: begin
        if (copyRequest) begin
          if (destCodeBad) begin
            // Set wins over a same-cycle software clear
            st_d.dstSel[DEST_ERR_BIT] = 1'b1;
          end else if (selErr || keyCopyErr) begin
            st_d.base = fdpc_dest_base(codeNow);
            st_d.ram.addr = fdpc_dest_base(codeNow);
            st_d.ram.wdata = {5'h00, selErr, keyCopyErr, 1'b1};
            st_d.ram.we = 1'b1;
            st_d.dlDone = 1'b1;
          end else begin
            st_d.base = fdpc_dest_base(codeNow);
            st_d.idx = 12'h000;
            st_d.romAddr = 12'h000;
            st_d.busy = 1'b1;
            st_d.mismatch = 1'b0;
            st_d.fsm = DL_COPY_RD;
          end
        end
      end
      DL_COPY_RD: begin
        st_d.fsm = DL_COPY_WR;
      end
      DL_COPY_WR: begin
        st_d.ram.addr = {st_q.base[23:12], st_q.idx};
        st_d.ram.wdata = romData;
        st_d.ram.we = 1'b1;
        if (st_q.idx == ROUTINE_LAST) begin
          st_d.idx = 12'h000;
          st_d.romAddr = 12'h000;
          st_d.fsm = DL_VER_RD;
        end else begin
          st_d.idx = st_q.idx + 12'h001;
          st_d.romAddr = st_q.idx + 12'h001;
          st_d.fsm = DL_COPY_RD;
        end
      end
      // Both memories answer one cycle after the address stands, so the pair
      // for byte i arrives in the next VER_RD, or in DL_RESULT for the last
      DL_VER_RD: begin
        if (st_q.idx != 12'h000 && ramRdata != romData) begin
          st_d.mismatch = 1'b1;
        end
        st_d.ram.addr = {st_q.base[23:12], st_q.idx};
        st_d.romAddr = st_q.idx;
        st_d.fsm = DL_VER_CMP;
      end
      DL_VER_CMP: begin
        // Address pair stands on both memories in this cycle
        if (st_q.idx == ROUTINE_LAST) begin
          st_d.fsm = DL_RESULT;
        end else begin
          st_d.idx = st_q.idx + 12'h001;
          st_d.fsm = DL_VER_RD;
        end
      end
      DL_RESULT: begin
        // Read-back of the last byte is folded in before the result is written
        st_d.mismatch = st_q.mismatch | (ramRdata != romData);
        st_d.ram.addr = st_q.base;
        st_d.ram.wdata = {7'h00, st_d.mismatch};
        st_d.ram.we = 1'b1;
        st_d.busy = 1'b0;
        st_d.dlDone = 1'b1;
        st_d.fsm = DL_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Standby drops everything as a reset does; nothing survives it
  always_ff @(posedge ref_clk) begin
    if (!rst_n || standby) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign destSelRdata = st_q.dstSel;
  assign copyBusy = st_q.busy;
  assign dlDone = st_q.dlDone;
  assign romAddr = st_q.romAddr;
  assign ramReq = st_q.ram;
  assign opDone = st_q.opDone;
  assign resultLowByte = st_q.result;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [12:0] wrCount;

  // Counts routine bytes written while the copy is running
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !st_q.busy) begin
      wrCount <= 13'h0000;
    end else if (st_q.ram.we) begin
      wrCount <= wrCount + 13'h0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || standby);

  sequence dlTrigOk;
    st_q.fsm == DL_IDLE && copyRequest && !destSelWe &&
      st_q.dstSel[6:0] <= DEST_CODE_MAX;
  endsequence

  sequence dlTrigClean;
    dlTrigOk ##0 (!selErr && !keyCopyErr);
  endsequence

  sequence progCall;
    opStart && opKind == OP_PROG;
  endsequence

  // A copy that ends on its own, not one cut short by reset or standby
  sequence copyEnd;
    $fell(copyBusy) && $past(rst_n) && !$past(standby);
  endsequence

  dest_err_flag_a: assert property (
    st_q.fsm == DL_IDLE && copyRequest && !destSelWe && st_q.dstSel[6:0] > DEST_CODE_MAX
    |=> destSelRdata[DEST_ERR_BIT] && !copyBusy && !ramReq.we)
    else $error("bad destination code did not abort");

  base_map_a: assert property (
    dlTrigClean |=> ##2 (ramReq.we && ramReq.addr == fdpc_dest_base($past(st_q.dstSel[6:0], 3))))
    else $error("first routine byte at wrong base");

  copy_len_a: assert property (
    copyEnd |-> wrCount == ROUTINE_BYTES)
    else $error("routine copy length wrong");

  key_fail_dl_a: assert property (
    dlTrigOk ##0 keyCopyErr |=> ramReq.we && dlDone && ramReq.wdata[KEY_CHECK_ERROR] &&
      ramReq.wdata[PASS_FAIL] && !copyBusy)
    else $error("download key error not reported");

  dl_result_a: assert property (
    copyEnd |-> dlDone && ramReq.we && ramReq.addr == $past(st_q.base) &&
      ramReq.wdata[7:3] == 5'h00)
    else $error("download result misplaced");

  init_freq_a: assert property (
    opStart && opKind == OP_INIT && !freqOk |=> opDone && resultLowByte == 8'h03)
    else $error("frequency error not reported");

  prog_protect_a: assert property (
    progCall |=> resultLowByte[PROTECT_STATE_ERROR] == $past(flashErrorFlag) &&
      resultLowByte[7] == 1'b0 && resultLowByte[3] == 1'b0)
    else $error("protect bit or zero bits wrong");

  prog_exec_a: assert property (
    progCall ##0 (bootSel || notErased) |=> resultLowByte[EXEC_ERROR])
    else $error("execution error not reported");

  prog_key_a: assert property (
    progCall |=> resultLowByte[OP_KEY_ERROR] == ($past(unlockKey) != KEY_PROG))
    else $error("programming key check wrong");

  prog_align_a: assert property (
    progCall ##0 (paramRegB[7:0] != ALIGN_LO && paramRegB[7:0] != ALIGN_HI)
    |=> resultLowByte[DEST_ADDR_ERROR] && resultLowByte[PASS_FAIL])
    else $error("unaligned destination accepted");

  pass_fail_or_a: assert property (
    opDone |-> resultLowByte[PASS_FAIL] == (|resultLowByte[7:1]) || $past(opKind) == 2'h3)
    else $error("pass/fail disagrees with error bits");

  // Selection errors skip the copy and report at once, upper bits clear
  sel_err_dl_a: assert property (
    dlTrigOk ##0 selErr |=> ramReq.we && dlDone && ramReq.wdata[SRC_SEL_ERROR] &&
      ramReq.wdata[7:3] == 5'h00 && !copyBusy)
    else $error("download selection error not reported");

  // A clean trigger starts the copy from the first routine byte
  copy_start_a: assert property (
    dlTrigClean |=> copyBusy && romAddr == 12'h000 && !dlDone)
    else $error("routine copy did not start");

  // The result byte is only written once the copy has finished
  busy_no_done_a: assert property (
    copyBusy |-> !dlDone)
    else $error("download done while still busy");

  // Every call is answered on the next cycle
  op_answer_a: assert property (
    opStart |=> opDone)
    else $error("operation not answered");

  // Software reads the result long after the call, so it must not drift
  result_hold_a: assert property (
    !opStart |=> $stable(resultLowByte))
    else $error("result changed without a call");

  // Initialization uses only the frequency and pass/fail bits
  init_zero_a: assert property (
    opStart && opKind == OP_INIT |=> resultLowByte[7:2] == 6'h00 &&
      resultLowByte[PASS_FAIL] == resultLowByte[FREQ_ERROR])
    else $error("initialization result bits wrong");

  // Source data held in the flash range is refused
  prog_source_a: assert property (
    progCall ##0 paramRegA <= FLASH_HI |=> resultLowByte[SOURCE_ADDR_ERROR] &&
      resultLowByte[PASS_FAIL])
    else $error("source inside flash accepted");

  // An erase block number past the last block fails the call
  erase_block_a: assert property (
    opStart && opKind == OP_ERASE && paramRegA > ERASE_BLK_MAX
    |=> resultLowByte[ERASE_BLK_ERROR] && resultLowByte[PASS_FAIL])
    else $error("bad erase block accepted");

endmodule : fdpc_top

// ===== sim/fdpc_mem_model.sv
// Behavioural routine ROM and on-chip RAM standing behind the download sequencer
`timescale 1ns/10ps
module fdpc_mem_model
  import fdpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [11:0] romAddr,
  output logic [7:0] romData,
  input wire fdpc_ram_req_t ramReq,
  output logic [7:0] ramRdata,
  input wire logic corrupt
);
  logic [7:0] mem [0:16383];
  logic inWin;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Only the three legal download areas exist; anything else is unmapped
  assign inWin = (ramReq.addr >= RAM_BASE0) && (ramReq.addr <= RAM_BASE2 + 24'h000FFF);

  initial begin
    romData = 8'h00;
    ramRdata = 8'h00;
  end

  // One-cycle synchronous ROM and RAM; an unmapped read toggles so stale data never matches
  always @(posedge ref_clk) begin
    romData <= romAddr[7:0] ^ {romAddr[11:8], romAddr[11:8]} ^ 8'h5C;
    if (ramReq.we && inWin) begin
      mem[ramReq.addr[13:0]] <= ramReq.wdata;
    end
    if (!inWin) begin
      ramRdata <= ~ramRdata;
    end else if (corrupt && ramReq.addr[11:0] == 12'h123) begin
      ramRdata <= ~mem[ramReq.addr[13:0]]; // Injected read-back fault
    end else begin
      ramRdata <= mem[ramReq.addr[13:0]];
    end
  end
endmodule : fdpc_mem_model

// ===== sim/fdpc_tb_top.sv
// Self-checking testbench for the flash download and parameter check block
`timescale 1ns/10ps
module fdpc_tb_top
  import fdpc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic standby = 1'b0;
  logic destSelWe = 1'b0;
  logic [7:0] destSelWdata = 8'h00;
  logic [7:0] destSelRdata;
  logic copyRequest = 1'b0;
  logic copyBusy;
  logic dlDone;
  logic progSelect = 1'b1;
  logic eraseSelect = 1'b0;
  logic [7:0] unlockKey = 8'h00;
  logic [7:0] arraySelect = 8'h00;
  logic flashErrorFlag = 1'b0;
  logic [11:0] romAddr;
  logic [7:0] romData;
  fdpc_ram_req_t ramReq;
  logic [7:0] ramRdata;
  logic opStart = 1'b0;
  fdpc_op_t opKind = OP_INIT;
  logic [31:0] paramRegA = 32'h00000000;
  logic [31:0] paramRegB = 32'h00000000;
  logic notErased = 1'b0;
  logic opDone;
  logic [7:0] resultLowByte;
  logic corrupt = 1'b0;
  int failures = 0;
  int total_checks = 0;
  int writes = 0;

  // ---------------------------------------------------------------
  // Clock, instances and write counter
  // ---------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;

  fdpc_top fdpc_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .standby(standby),
    .destSelWe(destSelWe), .destSelWdata(destSelWdata), .destSelRdata(destSelRdata),
    .copyRequest(copyRequest), .copyBusy(copyBusy), .dlDone(dlDone), .progSelect(progSelect),
    .eraseSelect(eraseSelect), .unlockKey(unlockKey), .arraySelect(arraySelect),
    .flashErrorFlag(flashErrorFlag), .romAddr(romAddr), .romData(romData), .ramReq(ramReq),
    .ramRdata(ramRdata), .opStart(opStart), .opKind(opKind), .paramRegA(paramRegA),
    .paramRegB(paramRegB), .notErased(notErased), .opDone(opDone),
    .resultLowByte(resultLowByte));

  fdpc_mem_model fdpc_mem_model_i (.ref_clk(ref_clk), .romAddr(romAddr), .romData(romData),
    .ramReq(ramReq), .ramRdata(ramRdata), .corrupt(corrupt));

  // Every RAM write strobe is counted so stray or missing writes show up
  always @(posedge ref_clk) begin
    if (ramReq.we === 1'b1) begin
      writes++;
    end
  end

  // ---------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chkBit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chkBit

  task automatic test_done;
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  // One check call; flags are {flash error, not erased, boot array, wrong key}
  task automatic op(input logic [1:0] k, input logic [31:0] a, input logic [31:0] b,
                    input logic [3:0] f, input logic [7:0] exp);
    @(posedge ref_clk);
    opStart <= 1'b1;
    opKind <= fdpc_op_t'(k);
    paramRegA <= a;
    paramRegB <= b;
    flashErrorFlag <= f[3];
    notErased <= f[2];
    arraySelect <= f[1] ? ARRAY_BOOT_SEL : 8'h00;
    unlockKey <= f[0] ? KEY_COPY : KEY_PROG;
    @(posedge ref_clk);
    opStart <= 1'b0;
    #1;
    chkBit("op done", 1'b1, opDone);
    chk8("op result", exp, resultLowByte);
  endtask : op

  // Select a window, request a copy and judge the result byte and the RAM image
  task automatic dl(input logic [6:0] code, input logic [7:0] key, input logic ps,
                    input logic es, input logic [7:0] expRes, input int expWrites);
    int n;
    int w0;
    int bad;
    logic [13:0] off;
    off = 14'(RAM_BASE0[13:0] + {code[1:0], 12'h000});
    @(posedge ref_clk);
    destSelWe <= 1'b1;
    destSelWdata <= {1'b0, code};
    unlockKey <= key;
    progSelect <= ps;
    eraseSelect <= es;
    @(posedge ref_clk);
    destSelWe <= 1'b0;
    copyRequest <= 1'b1;
    @(posedge ref_clk);
    copyRequest <= 1'b0;
    w0 = writes;
    #1;
    if (code > 7'h02) begin
      chk8("dest select", {1'b1, code}, destSelRdata);
      chkBit("dl done", 1'b0, dlDone);
      return;
    end
    chkBit("copy busy", expWrites > 1, copyBusy);
    n = 0;
    while (dlDone !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chkBit("dl done", 1'b1, dlDone);
    @(posedge ref_clk);
    #1;
    chk8("download result", expRes, fdpc_mem_model_i.mem[off]);
    chk8("write count low", 8'(expWrites), 8'(writes - w0));
    chk8("write count high", 8'(expWrites >> 8), 8'((writes - w0) >> 8));
    chkBit("copy busy end", 1'b0, copyBusy);
    if (expWrites > 1) begin
      bad = 0;
      for (int i = 1; i < 4096; i++) begin
        if (fdpc_mem_model_i.mem[off + 14'(i)] !== (8'(i) ^ {2{4'(i >> 8)}} ^ 8'h5C)) begin
          bad++;
        end
      end
      chk8("copied bytes in error", 8'h00, 8'(bad));
    end
  endtask : dl

  // ---------------------------------------------------------------
  // Test sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk8("dest select reset", 8'h00, destSelRdata);
    chk8("result reset", 8'h00, resultLowByte);
    // Initialization: frequency bounds on both sides
    op(2'h0, 32'h00000320, 32'h0, 4'h0, 8'h00);
    op(2'h0, 32'h0000031F, 32'h0, 4'h0, 8'h03);
    op(2'h0, 32'h00001388, 32'h0, 4'h0, 8'h00);
    op(2'h0, 32'h00001389, 32'h0, 4'h0, 8'h03);
    // Programming: addresses, alignment and execution errors
    op(2'h1, 32'h00FFA000, 32'h00000100, 4'h0, 8'h00);
    op(2'h1, 32'h00FFA000, 32'h00000180, 4'h0, 8'h00);
    op(2'h1, 32'h00FFA000, 32'h00000140, 4'h0, 8'h03);
    op(2'h1, 32'h00FFA000, 32'h00080000, 4'h0, 8'h03);
    op(2'h1, 32'h00000100, 32'h00000100, 4'h0, 8'h05);
    op(2'h1, 32'h00FFA000, 32'h00000100, 4'h8, 8'h41);
    op(2'h1, 32'h00FFA000, 32'h00000100, 4'h4, 8'h21);
    op(2'h1, 32'h00FFA000, 32'h00000100, 4'h2, 8'h21);
    op(2'h1, 32'h00FFA000, 32'h00000100, 4'h1, 8'h11);
    // Erasure: last legal block, first illegal one, then an undefined kind
    op(2'h2, 32'h00000013, 32'h0, 4'h0, 8'h00);
    op(2'h2, 32'h00000014, 32'h0, 4'h0, 8'h09);
    op(2'h2, 32'h00000000, 32'h0, 4'hC, 8'h61);
    op(2'h3, 32'h00000000, 32'h0, 4'h0, 8'h01);
    // Standby in mid-copy clears state and writes no result byte
    @(posedge ref_clk);
    destSelWe <= 1'b1;
    destSelWdata <= 8'h01;
    unlockKey <= KEY_COPY;
    @(posedge ref_clk);
    destSelWe <= 1'b0;
    copyRequest <= 1'b1;
    @(posedge ref_clk);
    copyRequest <= 1'b0;
    repeat (50) @(posedge ref_clk);
    standby <= 1'b1;
    @(posedge ref_clk);
    standby <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chkBit("standby busy", 1'b0, copyBusy);
    chk8("standby dest select", 8'h00, destSelRdata);
    chk8("standby result", 8'h00, resultLowByte);
    chk8("standby ram base", 8'h5C, fdpc_mem_model_i.mem[14'h2000]);
    // Refused codes, key and selection errors, then full copies to every window
    dl(7'h03, KEY_COPY, 1'b1, 1'b0, 8'h00, 0);
    dl(7'h7F, KEY_COPY, 1'b1, 1'b0, 8'h00, 0);
    dl(7'h00, KEY_PROG, 1'b1, 1'b0, 8'h03, 1);
    dl(7'h01, KEY_COPY, 1'b1, 1'b1, 8'h05, 1);
    dl(7'h02, KEY_COPY, 1'b0, 1'b0, 8'h05, 1);
    dl(7'h00, KEY_COPY, 1'b1, 1'b0, 8'h00, 4097);
    dl(7'h01, KEY_COPY, 1'b0, 1'b1, 8'h00, 4097);
    corrupt <= 1'b1;
    dl(7'h02, KEY_COPY, 1'b1, 1'b0, 8'h01, 4097);
    test_done();
  end

  // About 50,000 cycles are needed; the span leaves ample margin before cutting the run
  initial begin
    #(850000);
    failures++;
    test_done();
  end
endmodule : fdpc_tb_top
